// file: design/pri_cfg.svh
`ifndef PRI_CFG_SVH
`define PRI_CFG_SVH
// Functional notes
// - fixed mode: signature looked for at one configured offset per stream
// - automatic mode: first signature block searched at any frame offset
// - second block sits twelve bytes back from the frame end
// - first block is 12 signature, 4 group id, 4 sequence bytes
// - frame counts as instrumented only when the signature is seen
// - group id and sequence number taken from bytes after the signature
// - integrity coverage starts at the byte right after the signature
// - checksum adjust bytes are never interpreted by this port
// - reflected packet carries swapped IP source and destination
// - reflected length, MACs and fill come from configuration
// - transmit timestamp copied unchanged into the reflected packet
// - reflected packet leaves through this port's transmit side
// - configured fill overwrites any group signature in the payload
// - four user counters count frames meeting trigger-style conditions
// - one receive counter per IP quality-of-service value, eight total
// - IP, UDP and TCP checksums verified in hardware and counted
// - automatic mode also turns on sequence, latency, integrity, group rx

// ==========================================================
// register byte addresses
`define PRI_A_CTRL   12'h000
`define PRI_A_SIGOFF 12'h004
`define PRI_A_SIG0   12'h008
`define PRI_A_SIG1   12'h00c
`define PRI_A_SIG2   12'h010
`define PRI_A_RLEN   12'h014
`define PRI_A_DMACH  12'h018
`define PRI_A_DMACL  12'h01c
`define PRI_A_SMACH  12'h020
`define PRI_A_SMACL  12'h024
`define PRI_A_FILL   12'h028
`define PRI_A_ISTAT  12'h02c
`define PRI_A_IMASK  12'h030
`define PRI_A_UCSEL  12'h034
`define PRI_A_TRIG   12'h038
`define PRI_A_FGID   12'h03c
`define PRI_A_SEQ    12'h040
`define PRI_A_INFO   12'h044
`define PRI_A_CNT    6'h02
`define PRI_CNT_QOS  4'h4
// ==========================================================
// frame byte positions and lengths
`define PRI_SIG_LAST 16'h000b
`define PRI_FLD_LEN  4'h8
`define PRI_P_ETH0   16'h000c
`define PRI_P_ETH1   16'h000d
`define PRI_P_IP     16'h000e
`define PRI_P_SRC    16'h001a
`define PRI_P_L4     16'h0022
`define PRI_P_HLEN   16'h0014
`define PRI_P_MAC2   16'h000c
`define PRI_P_MAC1   16'h0006
`define PRI_BLK2_LEN 16'h000c
`define PRI_REFL_MIN 16'h002e
`define PRI_ETH_IP0  8'h08
`define PRI_ETH_IP1  8'h00
`define PRI_IP_VIHL  8'h45
`define PRI_PR_TCP   8'h06
`define PRI_PR_UDP   8'h11
`define PRI_CK_GOOD  16'hffff
`define PRI_CTRL_RST 32'h0000_0000
`endif

// file: design/pri_pkg.sv
package pri_pkg;
  typedef struct packed {
    logic       valid;
    logic       eof;
    logic [7:0] data;
  } pri_rx_type;
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } pri_tx_type;
  typedef struct packed {
    logic        done;
    logic        instrumented;
    logic        fields_ok;
    logic [31:0] flow_group_id;
    logic [31:0] seq;
  } pri_result_type;
  typedef enum logic {
    PRI_IDLE = 1'b0,
    PRI_SEND = 1'b1
  } pri_state_type;
endpackage

// file: design/pri_port_rx_instr.sv
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ns
`include "pri_cfg.svh"
module pri_port_rx_instr (
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    nrst,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // receive byte stream
  input  wire pri_pkg::pri_rx_type     rx,
  // reflected packet stream
  output pri_pkg::pri_tx_type          tx,
  input  wire logic                    tx_ready,
  // results and events
  output pri_pkg::pri_result_type      result,
  output logic                         di_start,
  output logic      [15:0]             di_offset,
  output logic      [3:0]              func_en,
  output logic                         capture_trig,
  output logic                         irq
);
  function automatic logic [7:0] bsel(input logic [95:0] v,
                                      input logic [15:0] n);
    bsel = v[8*n[3:0] +: 8];
  endfunction
  function automatic logic [15:0] fold(input logic [31:0] a);
    logic [16:0] s;
    s = {1'b0, a[15:0]} + {1'b0, a[31:16]};
    fold = s[15:0] + {15'h0000, s[16]};
  endfunction

  // ==========================================================
  // configuration registers
  logic [31:0] ctrl_q, sigoff_q, rlen_q, fill_q, ucsel_q, trig_q;
  logic [95:0] sig_q;
  logic [47:0] dmac_q, smac_q;
  logic [3:0]  istat_q, imask_q;
  logic        wr;
  logic        auto_en, refl_en;

  assign wr      = psel & penable & pwrite;
  assign auto_en = ctrl_q[0];
  assign refl_en = ctrl_q[1];
  assign func_en = ctrl_q[5:2] | {4{auto_en}};

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_q   <= `PRI_CTRL_RST;
      sigoff_q <= `PRI_CTRL_RST;
      sig_q    <= {3{`PRI_CTRL_RST}};
      rlen_q   <= `PRI_CTRL_RST;
      dmac_q   <= 48'h0000_0000_0000;
      smac_q   <= 48'h0000_0000_0000;
      fill_q   <= `PRI_CTRL_RST;
      imask_q  <= 4'h0;
      ucsel_q  <= `PRI_CTRL_RST;
      trig_q   <= `PRI_CTRL_RST;
    end else if (wr) begin
      unique case (paddr)
        `PRI_A_CTRL:   ctrl_q          <= pwdata;
        `PRI_A_SIGOFF: sigoff_q        <= pwdata;
        `PRI_A_SIG0:   sig_q[95:64]    <= pwdata;
        `PRI_A_SIG1:   sig_q[63:32]    <= pwdata;
        `PRI_A_SIG2:   sig_q[31:0]     <= pwdata;
        `PRI_A_RLEN:   rlen_q          <= pwdata;
        `PRI_A_DMACH:  dmac_q[47:32]   <= pwdata[15:0];
        `PRI_A_DMACL:  dmac_q[31:0]    <= pwdata;
        `PRI_A_SMACH:  smac_q[47:32]   <= pwdata[15:0];
        `PRI_A_SMACL:  smac_q[31:0]    <= pwdata;
        `PRI_A_FILL:   fill_q          <= pwdata;
        `PRI_A_IMASK:  imask_q         <= pwdata[3:0];
        `PRI_A_UCSEL:  ucsel_q         <= pwdata;
        `PRI_A_TRIG:   trig_q          <= pwdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // receive byte position and signature window
  logic [15:0] pos_q;
  logic [95:0] win_q, win;
  logic [7:0]  prev_q;
  logic        found_q, hit, instr_q, fok_q;
  logic [3:0]  fld_cnt_q;
  logic [63:0] fld_q;

  assign win = {win_q[87:0], rx.data};
  // full-pattern compare at every byte, only the first one counts
  assign hit = rx.valid && !found_q && win == sig_q
            && pos_q >= `PRI_SIG_LAST
            && (auto_en
                || pos_q == sigoff_q[15:0] + `PRI_SIG_LAST);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pos_q  <= 16'h0000;
      win_q  <= 96'h0;
      prev_q <= 8'h00;
    end else if (rx.valid) begin
      pos_q  <= rx.eof ? 16'h0000 : pos_q + 16'h0001;
      win_q  <= win;
      prev_q <= rx.data;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      found_q   <= 1'b0;
      fld_cnt_q <= 4'h0;
      fld_q     <= 64'h0;
      instr_q   <= 1'b0;
      fok_q     <= 1'b0;
    end else if (rx.valid) begin
      if (hit) begin
        fld_cnt_q <= `PRI_FLD_LEN;
      end else if (fld_cnt_q != 4'h0) begin
        fld_q     <= {fld_q[55:0], rx.data};
        fld_cnt_q <= fld_cnt_q - 4'h1;
      end
      if (rx.eof) begin
        instr_q   <= found_q | hit;
        fok_q     <= found_q && fld_cnt_q == 4'h0;
        found_q   <= 1'b0;
        fld_cnt_q <= 4'h0;
      end else if (hit) begin
        found_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      di_start  <= 1'b0;
      di_offset <= 16'h0000;
    end else begin
      di_start <= hit & ~rx.eof;
      if (hit)
        di_offset <= pos_q + 16'h0001;
    end
  end

  // ==========================================================
  // IP header capture and checksum sums
  logic [7:0]  hdr_q [0:19];
  logic [95:0] blk2_q;
  logic        ipv4_q;
  logic [31:0] ips_q, l4s_q;
  logic [15:0] ip_end, word;
  logic [4:0]  hidx;
  logic        in_ip, in_ph, in_l4;

  assign word   = {prev_q, rx.data};
  assign hidx   = 5'(pos_q - `PRI_P_IP);
  assign ip_end = {hdr_q[2], hdr_q[3]} + `PRI_P_IP;
  assign in_ip  = pos_q >= `PRI_P_IP && pos_q < `PRI_P_L4;
  assign in_ph  = pos_q >= `PRI_P_SRC && pos_q < `PRI_P_L4;
  assign in_l4  = pos_q >= `PRI_P_L4 && pos_q < ip_end;

  always_ff @(posedge clock) begin
    if (rx.valid && in_ip)
      hdr_q[hidx] <= rx.data;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ipv4_q <= 1'b0;
      blk2_q <= 96'h0;
    end else if (rx.valid) begin
      if (pos_q == `PRI_P_ETH0)
        ipv4_q <= rx.data == `PRI_ETH_IP0;
      else if (pos_q == `PRI_P_ETH1 || pos_q == `PRI_P_IP)
        ipv4_q <= ipv4_q && rx.data == (pos_q == `PRI_P_IP ?
                                        `PRI_IP_VIHL : `PRI_ETH_IP1);
      else if (pos_q < `PRI_P_ETH0)
        ipv4_q <= 1'b0;
      if (rx.eof)
        blk2_q <= win;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ips_q <= 32'h0000_0000;
      l4s_q <= 32'h0000_0000;
    end else if (rx.valid) begin
      if (pos_q == 16'h0000) begin
        ips_q <= 32'h0000_0000;
        l4s_q <= 32'h0000_0000;
      end else begin
        if (in_ip && pos_q[0])
          ips_q <= ips_q + {16'h0000, word};
        if ((in_ph || in_l4) && pos_q[0])
          l4s_q <= l4s_q + {16'h0000, word};
        else if (in_l4 && pos_q == ip_end - 16'h0001)
          l4s_q <= l4s_q + {16'h0000, rx.data, 8'h00};
      end
    end
  end

  // ==========================================================
  // end-of-frame results and counters
  logic        done_q;
  logic [7:0]  cond, proto;
  logic [31:0] l4tot;
  logic        ip_ok, l4_chk, l4_ok;
  logic [31:0] cnt_q [0:15];
  logic [31:0] fgid_q, seq_q;

  assign proto  = hdr_q[9];
  assign l4tot  = l4s_q + {24'h00_0000, proto}
                + {16'h0000, {hdr_q[2], hdr_q[3]} - `PRI_P_HLEN};
  assign ip_ok  = fold(ips_q) == `PRI_CK_GOOD;
  assign l4_chk = ipv4_q && (proto == `PRI_PR_TCP || proto == `PRI_PR_UDP);
  assign l4_ok  = fold(l4tot) == `PRI_CK_GOOD;
  // shared condition vector for user counters and capture trigger
  assign cond = {refl_en & ipv4_q, l4_chk & ~l4_ok, l4_chk & l4_ok,
                 ipv4_q & ~ip_ok, ipv4_q & ip_ok, ipv4_q, instr_q, 1'b1};

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      done_q       <= 1'b0;
      capture_trig <= 1'b0;
    end else begin
      done_q       <= rx.valid & rx.eof;
      capture_trig <= done_q && (cond & trig_q[7:0]) != 8'h00;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 16; i++)
        cnt_q[i] <= 32'h0000_0000;
    end else begin
      // software may preset a counter; a same-cycle count wins
      if (wr && paddr[11:6] == `PRI_A_CNT)
        cnt_q[paddr[5:2]] <= pwdata;
      if (done_q) begin
        for (int i = 0; i < 4; i++)
          if ((cond & ucsel_q[8*i +: 8]) != 8'h00)
            cnt_q[i] <= cnt_q[i] + 32'h0000_0001;
        // precedence 0..7 lands on counters 4..11, clear of user counters
        if (ipv4_q)
          cnt_q[`PRI_CNT_QOS + {1'b0, hdr_q[1][7:5]}] <=
            cnt_q[`PRI_CNT_QOS + {1'b0, hdr_q[1][7:5]}]
            + 32'h0000_0001;
        if (ipv4_q)
          cnt_q[ip_ok ? 12 : 13] <= cnt_q[ip_ok ? 12 : 13]
                                  + 32'h0000_0001;
        if (l4_chk)
          cnt_q[l4_ok ? 14 : 15] <= cnt_q[l4_ok ? 14 : 15]
                                  + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fgid_q <= 32'h0000_0000;
      seq_q  <= 32'h0000_0000;
      result <= '0;
    end else begin
      result.done <= done_q;
      if (done_q) begin
        result.instrumented <= instr_q;
        result.fields_ok    <= fok_q;
        if (fok_q) begin
          fgid_q               <= fld_q[63:32];
          seq_q                <= fld_q[31:0];
          result.flow_group_id <= fld_q[63:32];
          result.seq           <= fld_q[31:0];
        end
      end
    end
  end

  // ==========================================================
  // reflection transmitter
  pri_pkg::pri_state_type state_q;
  logic [7:0]  thdr_q [0:19];
  logic [95:0] tblk2_q;
  logic [15:0] tlen_q, tpos_q, hi;
  logic [7:0]  tb;
  logic        start, drop, sent, tload;

  assign start = done_q & refl_en & ipv4_q;
  assign drop  = start && state_q == pri_pkg::PRI_SEND;
  assign tload = state_q == pri_pkg::PRI_SEND && (!tx.valid || tx_ready);
  assign sent  = tload && tpos_q == tlen_q - 16'h0001;
  assign hi    = tpos_q - `PRI_P_IP;

  always_comb begin
    if (tpos_q < `PRI_P_MAC1)
      tb = bsel({48'h0, dmac_q}, `PRI_P_MAC1 - 16'h0001 - tpos_q);
    else if (tpos_q < `PRI_P_MAC2)
      tb = bsel({48'h0, smac_q}, `PRI_P_MAC2 - 16'h0001 - tpos_q);
    else if (tpos_q == `PRI_P_ETH0)
      tb = `PRI_ETH_IP0;
    else if (tpos_q == `PRI_P_ETH1)
      tb = `PRI_ETH_IP1;
    else if (tpos_q < `PRI_P_L4)
      // address words swapped: header offsets 12..15 and 16..19
      tb = thdr_q[(hi >= 16'h000c) ? 5'(hi ^ 16'h001c) : hi[4:0]];
    else if (tpos_q < tlen_q - `PRI_BLK2_LEN)
      // fill replaces any group signature in the payload area
      tb = bsel({64'h0, fill_q}, {14'h0000, ~tpos_q[1:0]});
    else
      tb = bsel(tblk2_q, tlen_q - 16'h0001 - tpos_q);
  end

  always_ff @(posedge clock) begin
    if (start && state_q == pri_pkg::PRI_IDLE)
      for (int i = 0; i < 20; i++)
        thdr_q[i] <= hdr_q[i];
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= pri_pkg::PRI_IDLE;
      tblk2_q <= 96'h0;
      tlen_q  <= `PRI_REFL_MIN;
      tpos_q  <= 16'h0000;
      tx      <= '0;
    end else begin
      unique case (state_q)
        pri_pkg::PRI_IDLE: begin
          if (tx_ready)
            tx.valid <= 1'b0;
          if (start) begin
            state_q <= pri_pkg::PRI_SEND;
            tblk2_q <= blk2_q;
            tlen_q  <= rlen_q[15:0] < `PRI_REFL_MIN ?
                       `PRI_REFL_MIN : rlen_q[15:0];
            tpos_q  <= 16'h0000;
          end
        end
        pri_pkg::PRI_SEND: begin
          if (tload) begin
            tx.valid <= 1'b1;
            tx.data  <= tb;
            tx.last  <= sent;
            tpos_q   <= tpos_q + 16'h0001;
            if (sent)
              state_q <= pri_pkg::PRI_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // interrupts: set wins over a same-cycle clear
  logic [3:0] ev;
  assign ev  = {done_q & ipv4_q & ~ip_ok, drop, sent, done_q & instr_q};
  assign irq = (istat_q & imask_q) != 4'h0;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      istat_q <= 4'h0;
    else
      istat_q <= ev | (istat_q & ~((wr && paddr == `PRI_A_ISTAT) ?
                                   pwdata[3:0] : 4'h0));
  end

  // ==========================================================
  // apb read path, zero wait states
  logic [31:0] rd;
  logic        hit_a;

  always_comb begin
    hit_a = 1'b1;
    unique case (paddr)
      `PRI_A_CTRL:   rd = ctrl_q;
      `PRI_A_SIGOFF: rd = sigoff_q;
      `PRI_A_SIG0:   rd = sig_q[95:64];
      `PRI_A_SIG1:   rd = sig_q[63:32];
      `PRI_A_SIG2:   rd = sig_q[31:0];
      `PRI_A_RLEN:   rd = rlen_q;
      `PRI_A_DMACH:  rd = {16'h0000, dmac_q[47:32]};
      `PRI_A_DMACL:  rd = dmac_q[31:0];
      `PRI_A_SMACH:  rd = {16'h0000, smac_q[47:32]};
      `PRI_A_SMACL:  rd = smac_q[31:0];
      `PRI_A_FILL:   rd = fill_q;
      `PRI_A_ISTAT:  rd = {28'h000_0000, istat_q};
      `PRI_A_IMASK:  rd = {28'h000_0000, imask_q};
      `PRI_A_UCSEL:  rd = ucsel_q;
      `PRI_A_TRIG:   rd = trig_q;
      `PRI_A_FGID:   rd = fgid_q;
      `PRI_A_SEQ:    rd = seq_q;
      `PRI_A_INFO:   rd = {di_offset, 7'h00, state_q, func_en,
                           1'b0, ipv4_q, fok_q, instr_q};
      default: begin
        hit_a = paddr[11:6] == `PRI_A_CNT;
        rd    = hit_a ? cnt_q[paddr[5:2]] : 32'h0000_0000;
      end
    endcase
  end

  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~hit_a;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
      prdata <= rd;
  end
endmodule

// file: testbench/pri_checker.sv
`timescale 1ns/1ns
`include "pri_cfg.svh"
module pri_checker (
  // clock and reset
  input wire logic                    clock,
  input wire logic                    nrst,
  // register bus
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [11:0]             paddr,
  input wire logic [31:0]             pwdata,
  input wire logic                    pready,
  // streams and results
  input wire pri_pkg::pri_rx_type     rx,
  input wire pri_pkg::pri_tx_type     tx,
  input wire logic                    tx_ready,
  input wire pri_pkg::pri_result_type result,
  input wire logic                    di_start,
  input wire logic [15:0]             di_offset,
  input wire logic [3:0]              func_en,
  input wire logic                    capture_trig,
  input wire logic                    irq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  logic [15:0] rx_n_q;
  logic [15:0] tx_n_q;
  // ==========================================
  // byte index inside the current frame
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rx_n_q <= 16'h0000;
      tx_n_q <= 16'h0000;
    end else begin
      if (rx.valid)
        rx_n_q <= rx.eof ? 16'h0000 : rx_n_q + 16'h0001;
      if (tx.valid && tx_ready)
        tx_n_q <= tx.last ? 16'h0000 : tx_n_q + 16'h0001;
    end
  end
  sequence s_eof_taken;
    rx.valid && rx.eof;
  endsequence
  sequence s_tx_end;
    tx.valid && tx_ready && tx.last;
  endsequence
  // ==========================================
  // properties
  a_done_after_eof: assert property (s_eof_taken |-> ##2 result.done)
    else $error("result not done two cycles after eof");
  a_done_cause: assert property (result.done |->
    $past(rx.valid, 2) && $past(rx.eof, 2))
    else $error("result done without an eof");
  a_di_offset: assert property (di_start |-> di_offset == rx_n_q)
    else $error("integrity start offset wrong");
  a_func_auto: assert property (psel && penable && pwrite &&
    paddr == `PRI_A_CTRL && pwdata[0] |=> func_en == 4'hf)
    else $error("auto mode did not enable receive functions");
  a_tx_hold: assert property (tx.valid && !tx_ready |=> tx.valid &&
    $stable(tx.data) && $stable(tx.last))
    else $error("tx byte changed while stalled");
  a_tx_gap: assert property (s_tx_end |=> !tx.valid)
    else $error("tx valid right after last byte");
  a_tx_min_len: assert property (s_tx_end |-> tx_n_q >= 16'h002d)
    else $error("reflected frame too short");
  a_trig_done: assert property (capture_trig |-> result.done)
    else $error("capture trigger outside frame result");
  a_irq_masked: assert property (psel && penable && pwrite &&
    paddr == `PRI_A_IMASK && pwdata == 32'h0000_0000 |=> !irq)
    else $error("irq high with all sources masked");
  a_pready_now: assert property (psel && penable |-> pready)
    else $error("pready late");
endmodule
bind pri_port_rx_instr pri_checker u_chk (.clock, .nrst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .rx, .tx, .tx_ready, .result,
  .di_start, .di_offset, .func_en, .capture_trig, .irq);

// file: testbench/pri_far_end.sv
`timescale 1ns/1ns
module pri_far_end (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                nrst,
  // frames toward the port
  output pri_pkg::pri_rx_type      rx,
  // reflected frames back
  input  wire pri_pkg::pri_tx_type tx,
  output logic                     tx_ready
);
  logic       stall = 1'b0;
  logic [1:0] ph_q = 2'h0;
  int         last_at = -1;
  logic [7:0] txq [$];
  initial begin
    rx = '0;
    tx_ready = 1'b1;
  end
  // stalls one cycle in three so held tx data is exercised
  always @(posedge clock) begin
    ph_q <= (!nrst || ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
    tx_ready <= !(stall && ph_q == 2'h0);
    if (tx.valid && tx_ready) begin
      if (tx.last)
        last_at = txq.size();
      txq.push_back(tx.data);
    end
  end
  // idle data shows the inverse of the last byte, never a stale copy
  task automatic send(input logic [7:0] f [$]);
    foreach (f[i]) begin
      rx <= '{1'b1, i == f.size() - 1, f[i]};
      @(posedge clock);
    end
    rx <= '{1'b0, 1'b0, ~f[f.size() - 1]};
  endtask
endmodule

// file: testbench/pri_port_rx_instr_bench.sv
`timescale 1ns/1ns
`include "pri_cfg.svh"
module pri_port_rx_instr_bench;
  localparam logic [95:0] sig_pat = 96'h5a17_c3e8_9b02_f4d6_71ae_0c35;
  logic                    clock = 1'b0;
  logic                    nrst = 1'b0;
  logic                    psel = 1'b0;
  logic                    penable = 1'b0;
  logic                    pwrite = 1'b0;
  logic [11:0]             paddr = 12'h000;
  logic [31:0]             pwdata = 32'h0000_0000;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  pri_pkg::pri_rx_type     rx;
  pri_pkg::pri_tx_type     tx;
  logic                    tx_ready;
  pri_pkg::pri_result_type result;
  logic                    di_start;
  logic [15:0]             di_offset;
  logic [3:0]              func_en;
  logic                    capture_trig;
  logic                    irq;
  int                      n_errors = 0;
  int                      n_tests = 0;
  logic [7:0]              frm [$];
  logic [31:0]             rd;
  logic                    err;
  always #50 clock = ~clock;
  pri_port_rx_instr dut (.clock, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rx, .tx, .tx_ready, .result,
    .di_start, .di_offset, .func_en, .capture_trig, .irq);
  pri_far_end far (.clock, .nrst, .rx, .tx, .tx_ready);
  // ==========================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20)
      n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [11:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask
  task automatic mk(input int sp, input logic [2:0] pr);
    logic [175:0] hdr;
    logic [159:0] blk;
    hdr = {16'h0800, 8'h45, pr, 5'h00, 16'h0050, 32'h0000_0000,
           8'h40, 8'h11, 16'hbeef, 32'h0a00_0001, 32'h0a00_0102};
    blk = {sig_pat, 32'h1000_0000 + sp, 32'h0000_0100 + sp};
    frm = {};
    for (int i = 0; i < 80; i++)
      frm.push_back(8'(i * 7 + 3));
    for (int i = 0; i < 22; i++)
      frm[12 + i] = hdr[175 - 8 * i -: 8];
    if (sp >= 0)
      for (int i = 0; i < 20; i++)
        frm[sp + i] = blk[159 - 8 * i -: 8];
  endtask
  task automatic run(input int sp, input logic [2:0] pr);
    int k;
    mk(sp, pr);
    @(posedge clock);
    far.send(frm);
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (result.done !== 1'b1 && k < 10);
    if (k >= 10)
      n_errors++;
    @(posedge clock);
  endtask
  task automatic res(input logic i, input int sp);
    chk("instrumented", i, result.instrumented);
    if (i) begin
      chk("group id", 32'h1000_0000 + sp, result.flow_group_id);
      chk("seq", 32'h0000_0100 + sp, result.seq);
      chk("di_offset", sp + 12, di_offset);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================
  // tests
  initial begin
    int k;
    logic [95:0] mac;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    rdc("ctrl", `PRI_A_CTRL, `PRI_CTRL_RST);
    rdc("unmapped", 12'h0fc, 32'h0000_0000);
    chk("pslverr", 1'b1, err);
    $display("test reset done");
    apb(1'b1, `PRI_A_CTRL, 32'h0000_0001);
    apb(1'b1, `PRI_A_SIG0, sig_pat[95:64]);
    apb(1'b1, `PRI_A_SIG1, sig_pat[63:32]);
    apb(1'b1, `PRI_A_SIG2, sig_pat[31:0]);
    apb(1'b1, `PRI_A_UCSEL, 32'h0000_0002);
    apb(1'b1, `PRI_A_TRIG, 32'h0000_0002);
    @(negedge clock);
    chk("func_en", 4'hf, func_en);
    for (int p = 0; p < 8; p++) begin
      run(34 + 2 * p, 3'(p));
      res(1'b1, 34 + 2 * p);
    end
    for (int p = 0; p < 8; p++)
      rdc("qos count", 12'h090 + 12'(4 * p), 32'h0000_0001);
    rdc("user count", 12'h080, 32'h0000_0008);
    rdc("ip error count", 12'h0b4, 32'h0000_0008);
    $display("test auto search done");
    apb(1'b1, `PRI_A_CTRL, 32'h0000_0000);
    apb(1'b1, `PRI_A_SIGOFF, 32'h0000_0028);
    run(38, 3'h0);
    res(1'b0, 38);
    run(40, 3'h1);
    res(1'b1, 40);
    run(-1, 3'h0);
    res(1'b0, 0);
    $display("test fixed offset done");
    apb(1'b1, `PRI_A_IMASK, 32'h0000_0001);
    @(negedge clock);
    chk("irq", 1'b1, irq);
    apb(1'b1, `PRI_A_ISTAT, 32'h0000_000f);
    @(negedge clock);
    chk("irq", 1'b0, irq);
    rdc("istat", `PRI_A_ISTAT, 32'h0000_0000);
    apb(1'b1, `PRI_A_IMASK, 32'h0000_0000);
    $display("test interrupt done");
    mac = {48'h0a0b_0c0d_0e0f, 48'h1112_1314_1516};
    apb(1'b1, `PRI_A_CTRL, 32'h0000_0003);
    apb(1'b1, `PRI_A_RLEN, 32'h0000_0050);
    apb(1'b1, `PRI_A_DMACH, 32'h0000_0a0b);
    apb(1'b1, `PRI_A_DMACL, 32'h0c0d_0e0f);
    apb(1'b1, `PRI_A_SMACH, 32'h0000_1112);
    apb(1'b1, `PRI_A_SMACL, 32'h1314_1516);
    // fill restores nothing here, so overwrite of the block is visible
    apb(1'b1, `PRI_A_FILL, 32'ha1b2_c3d4);
    far.stall = 1'b1;
    run(36, 3'h2);
    k = 0;
    while (far.txq.size() < 80 && k < 400) begin
      @(negedge clock);
      k++;
    end
    chk("tx length", 32'd80, far.txq.size());
    chk("tx last", 32'd79, far.last_at);
    for (int i = 0; i < 80 && i < far.txq.size(); i++)
      if (i < 12)
        chk("tx mac", mac[95 - 8 * i -: 8], far.txq[i]);
      else if (i < 34)
        chk("tx ip", frm[(i > 25 && i < 30) ? i + 4 :
          (i > 29 && i < 34) ? i - 4 : i], far.txq[i]);
      else if (i < 68)
        chk("tx fill", 8'(32'ha1b2_c3d4 >> (24 - 8 * (i % 4))),
          far.txq[i]);
      else
        chk("tx stamp", frm[i], far.txq[i]);
    @(posedge clock);
    rdc("istat", `PRI_A_ISTAT, 32'h0000_000b);
    $display("test reflection done");
    report_and_stop();
  end
  initial begin
    repeat (30000) @(posedge clock);
    n_errors++;
    report_and_stop();
  end
endmodule
